// ---- pkg/gated_prescaled_timer16_map.vh ----
// Register offsets, field positions, reset values and counts for the 16-bit timer.
// Assumes a single 100 MHz clock and a plain strobe-based register port.
//
// How it works
// R1 - Gate high plus internal clock accumulates counts
// R2 - Idle stops counting when idle_stop is set
// R3 - Prescaler divides selected clock by 1/8/64/256
// R4 - Prescaler cleared on count write, disable, reset
// R5 - Disabled timer halts the prescaler clock
// R6 - Control writes never alter the count
// R7 - Sleep counts only async external enabled clock
// R8 - Sleep counting still wraps at period match
// R9 - Period match sets flag; software clears it
// R10 - Gate falling edge also raises the interrupt
// R11 - Interrupt request passes only when enabled
// R12 - Control bit positions fixed; all reset zero
// R13 - Prescale codes 00,01,10,11 give 1,8,64,256
// R14 - Timer mode counts cycles, wraps at period
// R15 - Sync counter counts synchronised external rising edges
// R16 - Async counter counts edges; idle_stop gates idle
`ifndef GATED_PRESCALED_TIMER16_MAP_VH
`define GATED_PRESCALED_TIMER16_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define COUNT_VALUE_ADDR 16'h0100
`define PERIOD_VALUE_ADDR 16'h0102
`define TIMER_CONTROL_ADDR 16'h0104
`define IRQ_CTRL_ADDR 16'h0106

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define CTL_COUNT_ENABLE 15
`define CTL_IDLE_STOP 13
`define CTL_GATE_ENABLE 6
`define CTL_PRESCALE_HI 5
`define CTL_PRESCALE_LO 4
`define CTL_EXT_SYNC 2
`define CTL_CLOCK_SOURCE 1
`define CTL_WRITE_MASK 16'hA076

// Interrupt control word
`define IRQ_FLAG_BIT 0
`define IRQ_ENABLE_BIT 1

// ----------------------------------------------------------------
// Reset values and prescale terminal counts
// ----------------------------------------------------------------
`define PERIOD_RESET 16'hFFFF
`define CONTROL_RESET 16'h0000
`define PRE_DIV1_LAST 8'h00
`define PRE_DIV8_LAST 8'h07
`define PRE_DIV64_LAST 8'h3F
`define PRE_DIV256_LAST 8'hFF

`endif

// ---- design/gated_prescaled_timer16.v ----
// 16-bit timer/counter with prescaler, gated accumulation and period match.
// Assumes gate_clock_pin and the power-state inputs are synchronous to ref_clk.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "gated_prescaled_timer16_map.vh"

module gated_prescaled_timer16 (
  input wire ref_clk,
  input wire srst,
  input wire [15:0] addr,
  input wire [15:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [15:0] rdata,
  input wire gate_clock_pin,
  input wire cpu_idle,
  input wire cpu_sleep,
  output reg period_irq_flag,
  output reg timer_irq
);

  reg [15:0] count_value;
  reg [15:0] period_value;
  reg [15:0] timer_control;
  reg period_irq_enable;
  reg [7:0] prescale_cnt;
  reg ext_sync1;
  reg ext_sync2;
  reg ext_prev;
  reg gate_prev;

  wire count_enable = timer_control[`CTL_COUNT_ENABLE];
  wire idle_stop = timer_control[`CTL_IDLE_STOP];
  wire gate_en = timer_control[`CTL_GATE_ENABLE];
  wire [1:0] prescale_select = timer_control[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO];
  wire ext_sync_select = timer_control[`CTL_EXT_SYNC];
  wire clock_source_select = timer_control[`CTL_CLOCK_SOURCE];

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  wire wr_count = wr_en && (addr == `COUNT_VALUE_ADDR);
  wire wr_period = wr_en && (addr == `PERIOD_VALUE_ADDR);
  wire wr_control = wr_en && (addr == `TIMER_CONTROL_ADDR);
  wire wr_irq = wr_en && (addr == `IRQ_CTRL_ADDR);

  // ----------------------------------------------------------------
  // Input clock selection
  // ----------------------------------------------------------------
  // Async mode uses the raw pin history; sync mode a two-stage copy, so
  // sync counting lags the pin by two cycles more than async.
  wire ext_level = ext_sync_select ? ext_sync2 : gate_clock_pin;
  wire ext_rise = ext_level && !ext_prev; // R15 R16
  wire gated_mode = gate_en && !clock_source_select;

  // Internal clock is lost in sleep; only async external keeps going
  wire sleep_ok = !cpu_sleep ||
                  (clock_source_select && !ext_sync_select); // R7
  wire idle_ok = !(cpu_idle && idle_stop); // R2 R16

  reg tick_in;
  always @* begin
    if (clock_source_select) begin
      tick_in = ext_rise; // R15 R16
    end else if (gated_mode) begin
      tick_in = gate_clock_pin; // R1
    end else begin
      tick_in = 1'b1; // R14
    end
  end

  wire run = count_enable && sleep_ok && idle_ok;
  wire pre_in = run && tick_in;

  reg [7:0] pre_last;
  always @* begin
    case (prescale_select) // R13
      2'b00: pre_last = `PRE_DIV1_LAST;
      2'b01: pre_last = `PRE_DIV8_LAST;
      2'b10: pre_last = `PRE_DIV64_LAST;
      default: pre_last = `PRE_DIV256_LAST;
    endcase
  end

  wire pre_out = pre_in && (prescale_cnt >= pre_last); // R3
  wire match = (count_value == period_value);
  wire gate_fall = gated_mode && count_enable && gate_prev && !gate_clock_pin; // R10

  // ----------------------------------------------------------------
  // Prescaler and synchroniser
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      prescale_cnt <= 8'h00; // R4
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
      ext_prev <= 1'b0;
      gate_prev <= 1'b0;
    end else begin
      ext_sync1 <= gate_clock_pin;
      ext_sync2 <= ext_sync1;
      ext_prev <= ext_level;
      gate_prev <= gate_clock_pin;
      // Clearing count_enable clears; while disabled the count is frozen
      if (wr_count || (wr_control && count_enable && !wdata[`CTL_COUNT_ENABLE])) begin
        prescale_cnt <= 8'h00; // R4
      end else if (pre_in) begin // R5
        prescale_cnt <= pre_out ? 8'h00 : prescale_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter and registers
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      count_value <= 16'h0000;
      period_value <= `PERIOD_RESET;
      timer_control <= `CONTROL_RESET; // R12
      period_irq_enable <= 1'b0;
    end else begin
      if (wr_count) begin
        count_value <= wdata; // R6
      end else if (pre_out) begin
        count_value <= match ? 16'h0000 : count_value + 16'h0001; // R8 R14 R15
      end
      if (wr_period) begin
        period_value <= wdata;
      end
      if (wr_control) begin
        timer_control <= wdata & `CTL_WRITE_MASK; // R12
      end
      if (wr_irq) begin
        period_irq_enable <= wdata[`IRQ_ENABLE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flag and request
  // ----------------------------------------------------------------
  wire flag_set = (pre_out && match) || gate_fall; // R9 R10
  wire flag_clr = wr_irq && !wdata[`IRQ_FLAG_BIT];
  wire next_flag = flag_set || (period_irq_flag && !flag_clr); // R9

  always @(posedge ref_clk) begin
    if (srst) begin
      period_irq_flag <= 1'b0;
      timer_irq <= 1'b0;
    end else begin
      period_irq_flag <= next_flag; // R9
      timer_irq <= next_flag && (wr_irq ? wdata[`IRQ_ENABLE_BIT] : period_irq_enable); // R11
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      rdata <= 16'h0000;
    end else if (rd_en) begin
      if (addr == `COUNT_VALUE_ADDR) begin
        rdata <= count_value;
      end else if (addr == `PERIOD_VALUE_ADDR) begin
        rdata <= period_value;
      end else if (addr == `TIMER_CONTROL_ADDR) begin
        rdata <= timer_control;
      end else if (addr == `IRQ_CTRL_ADDR) begin
        rdata <= {14'h0000, period_irq_enable, period_irq_flag};
      end else begin
        rdata <= 16'h0000;
      end
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule

// ---- tb/gated_prescaled_timer16_props.sv ----
// Port checker for the 16-bit timer, bound to its top module.
// Assumes one ref_clk domain with synchronous srst.
`timescale 1ns/1ps
module gated_prescaled_timer16_props (
  input wire ref_clk,
  input wire srst,
  input wire [15:0] addr,
  input wire [15:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [15:0] rdata,
  input wire gate_clock_pin,
  input wire cpu_idle,
  input wire cpu_sleep,
  input wire period_irq_flag,
  input wire timer_irq
);
  // ------
  // Checks
  // ------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire irq_wr = wr_en && addr == 16'h0106;
  wire clr = irq_wr && !wdata[0];
  chk_flag_sticky: assert property (period_irq_flag && !clr |=> period_irq_flag)
    else $error("flag dropped");
  chk_irq_flag: assert property (timer_irq |-> period_irq_flag)
    else $error("irq without flag");
  chk_irq_hold: assert property (timer_irq && !irq_wr |=> timer_irq)
    else $error("irq dropped");
  chk_irq_off: assert property (irq_wr && wdata[1:0] == 2'b00 |=> !timer_irq)
    else $error("irq not masked");
  chk_rd_idle: assert property (!rd_en |=> rdata == 16'h0000)
    else $error("rdata not zero");
  chk_rd_unmapped: assert property (rd_en && addr == 16'h0108 |=> rdata == 16'h0000)
    else $error("unmapped read");
  chk_rd_period: assert property (wr_en && addr == 16'h0102 ##2 rd_en && addr == 16'h0102
    |=> rdata == $past(wdata, 3))
    else $error("period readback");
  chk_reset_clear: assert property (disable iff (1'b0) srst |=> !period_irq_flag && !timer_irq
    && rdata == 16'h0000)
    else $error("reset values");
endmodule
bind gated_prescaled_timer16 gated_prescaled_timer16_props u_props (.*);

// ---- tb/gate_source.sv ----
// External clock and gate source driving gate_clock_pin.
// Assumes the pin is sampled on ref_clk; it idles low between bursts.
`timescale 1ns/1ps
module gate_source (
  input wire ref_clk,
  output logic pin
);
  initial pin = 1'b0;
  // Each pulse is high for hi sampled edges, then low for lo
  task automatic burst(input int n, input int hi, input int lo);
    repeat (n) begin
      @(posedge ref_clk) pin <= 1'b1;
      repeat (hi) @(posedge ref_clk);
      pin <= 1'b0;
      repeat (lo - 1) @(posedge ref_clk);
    end
  endtask
endmodule

// ---- tb/gated_prescaled_timer16_tb.sv ----
// Self-checking bench for the 16-bit timer.
// Assumes 100 MHz ref_clk and the strobe register port.
`timescale 1ns/1ps
`include "gated_prescaled_timer16_map.vh"
module gated_prescaled_timer16_tb;
  logic ref_clk = 0, srst = 1, wr_en = 0, rd_en = 0, cpu_idle = 0, cpu_sleep = 0;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, v1, v2;
  wire pin, flag, irq;
  int err_total = 0, n_compared = 0;
  always #5 ref_clk = ~ref_clk;
  gated_prescaled_timer16 u_gated_prescaled_timer16 (.ref_clk(ref_clk), .srst(srst),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .gate_clock_pin(pin), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
    .period_irq_flag(flag), .timer_irq(irq));
  gate_source u_gate_source (.ref_clk(ref_clk), .pin(pin));
  // -----
  // Tasks
  // -----
  task automatic wr(input logic [15:0] a, d);
    @(posedge ref_clk) {wr_en, addr, wdata} <= {1'b1, a, d};
    @(posedge ref_clk) wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk) {rd_en, addr} <= {1'b1, a};
    @(posedge ref_clk) rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk(input string s, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rc(input logic [15:0] a, e, input string s);
    rd(a, v1);
    chk(s, e, v1);
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_reset;
    rc(`PERIOD_VALUE_ADDR, 16'hFFFF, "period");
    rc(`TIMER_CONTROL_ADDR, 16'h0000, "control");
    rc(16'h0108, 16'h0000, "unmapped");
    $display("reset done");
  endtask
  task automatic t_prescale;
    int n[4] = '{1, 8, 64, 256};
    for (int c = 0; c < 4; c++) begin
      wr(`TIMER_CONTROL_ADDR, {8'h80, 2'b00, c[1:0], 4'h0});
      rd(`COUNT_VALUE_ADDR, v1);
      repeat (4 * n[c] - 2) @(posedge ref_clk);
      rd(`COUNT_VALUE_ADDR, v2);
      chk("prescale", 16'h0004, v2 - v1);
    end
    $display("prescale done");
  endtask
  task automatic t_match;
    // Back to 1:1 so the match falls inside the short wait below
    wr(`TIMER_CONTROL_ADDR, 16'h8000);
    wr(`COUNT_VALUE_ADDR, 16'h0000);
    wr(`PERIOD_VALUE_ADDR, 16'h0003);
    wr(`IRQ_CTRL_ADDR, 16'h0002);
    repeat (8) @(posedge ref_clk);
    chk("irq", 16'h0001, {15'h0, irq});
    wr(`TIMER_CONTROL_ADDR, 16'h0000);
    repeat (5) @(posedge ref_clk);
    chk("flag", 16'h0001, {15'h0, flag});
    wr(`IRQ_CTRL_ADDR, 16'h0000);
    #1 chk("clear", 16'h0000, {14'h0, flag, irq});
    $display("match done");
  endtask
  task automatic t_idle;
    wr(`PERIOD_VALUE_ADDR, 16'hFFFF);
    rc(`PERIOD_VALUE_ADDR, 16'hFFFF, "period");
    @(posedge ref_clk) cpu_idle <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(`TIMER_CONTROL_ADDR, i ? 16'h8000 : 16'hA000);
      rd(`COUNT_VALUE_ADDR, v1);
      rd(`COUNT_VALUE_ADDR, v2);
      chk("idle", i ? 16'h0002 : 16'h0000, v2 - v1);
    end
    @(posedge ref_clk) cpu_idle <= 1'b0;
    $display("idle done");
  endtask
  task automatic t_ext;
    logic [15:0] c[4] = '{16'h8002, 16'h8006, 16'h8006, 16'h8000};
    logic [15:0] e[4] = '{16'h0005, 16'h0000, 16'h0005, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk) cpu_sleep <= (i != 2);
      wr(`TIMER_CONTROL_ADDR, c[i]);
      rd(`COUNT_VALUE_ADDR, v1);
      u_gate_source.burst(5, 2, 2);
      repeat (4) @(posedge ref_clk);
      rd(`COUNT_VALUE_ADDR, v2);
      chk("ext", e[i], v2 - v1);
    end
    @(posedge ref_clk) cpu_sleep <= 1'b0;
    $display("ext done");
  endtask
  task automatic t_gate;
    wr(`IRQ_CTRL_ADDR, 16'h0002);
    wr(`TIMER_CONTROL_ADDR, 16'h8040);
    rd(`COUNT_VALUE_ADDR, v1);
    chk("pre_irq", 16'h0000, {15'h0, irq});
    u_gate_source.burst(1, 10, 2);
    rd(`COUNT_VALUE_ADDR, v2);
    chk("gate", 16'h000A, v2 - v1);
    chk("gate_irq", 16'h0001, {15'h0, irq});
    $display("gate done");
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset;
    t_prescale;
    t_match;
    t_idle;
    t_ext;
    t_gate;
    test_done;
  end
  initial begin
    #200000;
    err_total++;
    test_done;
  end
endmodule
